/* File: design/lmbm_pkg.sv */
package lmbm_pkg;

   localparam int   DATA_W = 32;
   localparam int   LANES  = 4;

   // Access size codes presented by the core with each data request
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Lane-select patterns, leftmost bit is the most significant byte lane
   localparam logic [0:3] LANE_NONE    = 4'h0;
   localparam logic [0:3] LANE_BYTE0   = 4'h8;
   localparam logic [0:3] LANE_HI_HALF = 4'hC;
   localparam logic [0:3] LANE_LO_HALF = 4'h3;
   localparam logic [0:3] LANE_WORD    = 4'hF;

   localparam logic [0:31] WORD_ZERO = 32'h0000_0000;
   localparam logic [0:15] HALF_ZERO = 16'h0000;
   localparam logic [0:23] BYTE_PAD  = 24'h00_0000;

   typedef enum logic {CH_IDLE, CH_BUSY} lmbm_chan_state_type;

endpackage

/* File: design/lmbm_chan.sv */
`timescale 1ns/100ps
`default_nettype none
module lmbm_chan
   import lmbm_pkg::*;
#(
   parameter bit CAN_WRITE = 1'b1
)
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic cmd_valid,
   input  wire logic cmd_write,
   input  wire logic mem_ready,
   output logic      take,
   output logic      fin,
   output logic      strobe_r,
   output logic      rd_prog_r,
   output logic      wr_prog_r,
   output logic      taken_r,
   output logic      done_r,
   output logic      done_write_r
);

   lmbm_chan_state_type state_r;
   lmbm_chan_state_type state_nxt;
   logic                cur_write_r;
   logic                is_write;
   logic                rd_nxt;
   logic                wr_nxt;

   // Ready only counts while a transfer is outstanding
   assign fin      = (state_r == CH_BUSY) && mem_ready;                            // RL15
   // New transfer only when idle or at the edge that retires the current one
   assign take     = cmd_valid && ((state_r == CH_IDLE) || mem_ready);             // RL17
   assign is_write = CAN_WRITE && cmd_write;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         CH_IDLE:
         begin
            if (take)
               state_nxt = CH_BUSY;
         end
         CH_BUSY:
         begin
            if (fin && !take)
               state_nxt = CH_IDLE;
         end
         default:
            state_nxt = CH_IDLE;
      endcase
   end

   // In-progress drops after ready unless a same-kind transfer starts right then
   assign rd_nxt = take ? !is_write : (fin ? 1'b0 : rd_prog_r);                   // RL8 RL9
   assign wr_nxt = take ? is_write : (fin ? 1'b0 : wr_prog_r);                    // RL13

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r      <= CH_IDLE;
         strobe_r     <= 1'b0;                                                     // RL16
         rd_prog_r    <= 1'b0;
         wr_prog_r    <= 1'b0;
         taken_r      <= 1'b0;
         done_r       <= 1'b0;
         done_write_r <= 1'b0;
         cur_write_r  <= 1'b0;
      end
      else
      begin
         state_r      <= state_nxt;
         strobe_r     <= take;                                                     // RL7
         rd_prog_r    <= rd_nxt;
         wr_prog_r    <= wr_nxt;
         taken_r      <= take;
         done_r       <= fin;
         done_write_r <= fin && cur_write_r;
         if (take)
            cur_write_r <= is_write;
      end
   end

endmodule
`default_nettype wire

/* File: design/lmbm_master.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RL1] Every bus signal in both directions is active high.
// [RL2] The address is driven with the transfer strobe and is only guaranteed in that first cycle.
// [RL3] Four lane selects mark valid byte lanes, qualified by the strobe in the first cycle.
// [RL4] Lane selects only take 0000, 0001, 0010, 0100, 1000, 0011, 1100 or 1111, leftmost is MSB lane.
// [RL5] Write data is valid from the strobe until the cycle after ready is sampled high.
// [RL6] The memory writes only the byte lanes that are selected.
// [RL7] The transfer strobe is high for exactly the first cycle of each transfer.
// [RL8] Read-in-progress rises in a read's first cycle and falls in the cycle after ready.
// [RL9] A read starting right after ready keeps read-in-progress high without a gap.
// [RL10] The memory is expected to complete an access within one clock cycle; the bench memory holds ready low for up to 3 cycles and the master waits.
// [RL11] The fetch side is read-only with address, strobe, fetch-in-progress, data and ready.
// [RL12] Data side and fetch side each have their own ready input from memory.
// [RL13] Write-in-progress behaves like read-in-progress for writes, gapless on back-to-back.
// [RL14] Ready high means read data is valid at that edge or write data has been stored.
// [RL15] All bus activity is synchronous to the core clock, ready sampled on its rising edge.
// [RL16] During reset the strobes and in-progress outputs are held low.
// [RL17] No new transfer starts until ready has been sampled high for the current one.
module lmbm_master
   import lmbm_pkg::*;
#(
   parameter int ADDR_W = 32
)
(
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // Core data requests
   input  wire logic              dcmd_valid,
   input  wire logic              dcmd_write,
   input  wire logic [1:0]        dcmd_size,
   input  wire logic [0:ADDR_W-1] dcmd_addr,
   input  wire logic [0:31]       dcmd_wdata,
   output logic                   dcmd_taken_r,
   output logic                   drsp_valid_r,
   output logic                   drsp_write_r,
   output logic [0:31]            drsp_rdata_r,
   // Core fetch requests
   input  wire logic              fcmd_valid,
   input  wire logic [0:ADDR_W-1] fcmd_addr,
   output logic                   fcmd_taken_r,
   output logic                   frsp_valid_r,
   output logic [0:31]            frsp_instr_r,
   // Data-side local bus
   output logic [0:ADDR_W-1]      data_addr_r,
   output logic [0:3]             lane_sel_r,
   output logic [0:31]            data_write_r,
   output logic                   data_transfer_strobe_r,
   output logic                   read_strobe_r,
   output logic                   write_strobe_r,
   input  wire logic [0:31]       data_read,
   input  wire logic              data_side_ready,
   // Instruction-side local bus
   output logic [0:ADDR_W-1]      instr_addr_r,
   output logic                   fetch_transfer_strobe_r,
   output logic                   fetch_in_progress_r,
   input  wire logic [0:31]       instr,
   input  wire logic              fetch_side_ready
);

   if (ADDR_W < 2)
   begin : g_bad_width
      $error("ADDR_W must cover the two byte-offset bits");
   end

   logic           rst_meta_r;
   logic           rst_sync_r;
   logic           d_take;
   logic           d_fin;
   logic           f_take;
   logic           f_fin;
   logic           d_done;
   logic           d_done_wr;
   logic           f_done;
   logic [1:0]     d_off;
   logic [0:3]     lane_nxt;
   logic [0:31]    wdata_nxt;
   logic [1:0]     rd_size_r;
   logic [1:0]     rd_off_r;
   logic [0:7]     rd_byte;
   logic [0:15]    rd_half;
   logic [0:31]    rdata_steered;
   logic [0:31]    rd_capture_r;
   logic [0:31]    instr_capture_r;

   // Reset asserts at once, releases two edges later so no flop sees a ragged release
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Ready comes from memory logic on this clock, so it is used unsynchronised
   lmbm_chan #(
      .CAN_WRITE (1'b1)
   ) u_data_chan (
      .clk          (core_clk),
      .rst_b        (rst_sync_r),
      .cmd_valid    (dcmd_valid),
      .cmd_write    (dcmd_write),
      .mem_ready    (data_side_ready),                                           // RL12
      .take         (d_take),
      .fin          (d_fin),
      .strobe_r     (data_transfer_strobe_r),                                    // RL1
      .rd_prog_r    (read_strobe_r),
      .wr_prog_r    (write_strobe_r),
      .taken_r      (dcmd_taken_r),
      .done_r       (d_done),
      .done_write_r (d_done_wr)
   );

   // Fetch side never writes, so its write-in-progress is left unconnected
   lmbm_chan #(
      .CAN_WRITE (1'b0)
   ) u_fetch_chan (
      .clk          (core_clk),
      .rst_b        (rst_sync_r),
      .cmd_valid    (fcmd_valid),
      .cmd_write    (1'b0),                                                     // RL11
      .mem_ready    (fetch_side_ready),                                          // RL12
      .take         (f_take),
      .fin          (f_fin),
      .strobe_r     (fetch_transfer_strobe_r),
      .rd_prog_r    (fetch_in_progress_r),
      .wr_prog_r    (),
      .taken_r      (fcmd_taken_r),
      .done_r       (f_done),
      .done_write_r ()
   );

   assign d_off = dcmd_addr[ADDR_W-2:ADDR_W-1];

   // Misaligned offsets are folded down so only legal patterns reach the bus
   assign lane_nxt =
      (dcmd_size == SIZE_BYTE) ? (LANE_BYTE0 >> d_off) :
      (dcmd_size == SIZE_HALF) ? (d_off[1] ? LANE_LO_HALF : LANE_HI_HALF) :
      (dcmd_size == SIZE_WORD) ? LANE_WORD : LANE_NONE;                           // RL4

   // Narrow stores are replicated over all lanes; lane selects pick the real one
   assign wdata_nxt =
      (dcmd_size == SIZE_BYTE) ? {4{dcmd_wdata[24:31]}} :
      (dcmd_size == SIZE_HALF) ? {2{dcmd_wdata[16:31]}} : dcmd_wdata;             // RL6

   // Load steering: selected byte or halfword moves to the low end, zero filled
   assign rd_byte = data_read[8*rd_off_r +: 8];
   assign rd_half = rd_off_r[1] ? data_read[16:31] : data_read[0:15];
   assign rdata_steered =
      (rd_size_r == SIZE_BYTE) ? {BYTE_PAD, rd_byte} :
      (rd_size_r == SIZE_HALF) ? {HALF_ZERO, rd_half} : data_read;

   // Address and lanes load only when a transfer starts and then simply hold
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
      begin
         data_addr_r <= '0;
         lane_sel_r  <= LANE_NONE;
         rd_size_r   <= SIZE_WORD;
         rd_off_r    <= 2'h0;
      end
      else if (d_take)
      begin
         data_addr_r <= dcmd_addr;                                               // RL2
         lane_sel_r  <= dcmd_write ? lane_nxt : LANE_WORD;                       // RL3
         rd_size_r   <= dcmd_size;
         rd_off_r    <= d_off;
      end
   end

   // Write data stays put through ready and is released only afterwards
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         data_write_r <= WORD_ZERO;
      else if (d_take && dcmd_write)
         data_write_r <= wdata_nxt;                                              // RL5
      else if (d_fin)
         data_write_r <= WORD_ZERO;                                              // RL5
   end

   // Read data is only valid at the edge where ready is high
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         rd_capture_r <= WORD_ZERO;
      else if (d_fin && read_strobe_r)
         rd_capture_r <= rdata_steered;                                          // RL14
   end

   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
      begin
         drsp_valid_r <= 1'b0;
         drsp_write_r <= 1'b0;
         drsp_rdata_r <= WORD_ZERO;
      end
      else
      begin
         drsp_valid_r <= d_done;
         drsp_write_r <= d_done_wr;
         drsp_rdata_r <= rd_capture_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         instr_addr_r <= '0;
      else if (f_take)
         instr_addr_r <= fcmd_addr;                                              // RL2 RL11
   end

   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         instr_capture_r <= WORD_ZERO;
      else if (f_fin)
         instr_capture_r <= instr;                                               // RL14
   end

   // One extra stage keeps every core-side output on a flop
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
      begin
         frsp_valid_r <= 1'b0;
         frsp_instr_r <= WORD_ZERO;
      end
      else
      begin
         frsp_valid_r <= f_done;
         frsp_instr_r <= instr_capture_r;
      end
   end

endmodule
`default_nettype wire

/* File: bench/lmbm_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lmbm_mem_model
(
   input  wire logic        clk,
   input  wire logic        strobe,
   input  wire logic        wr,
   input  wire logic [0:31] addr,
   input  wire logic [0:3]  lanes,
   input  wire logic [0:31] wdata,
   input  wire logic [3:0]  lat,
   output logic             ready,
   output logic [0:31]      rdata
);
   logic [0:31] mem [16];
   logic [3:0]  idx_r;
   logic [0:3]  lanes_r;
   logic        wr_r;
   logic        busy_r = 1'b0;
   logic [3:0]  cnt_r = 4'h0;
   logic [0:31] last_r = 32'h0000_0000;
   // Address and lanes only trusted in the strobe cycle, so capture them there
   wire logic [3:0] idx = strobe ? addr[26:29] : idx_r;
   wire logic [0:3] wl  = strobe ? lanes : lanes_r;
   wire logic       wrr = strobe ? wr : wr_r;

   initial
   begin
      for (int i = 0; i < 16; i++)
         mem[i] = 32'hA5A5_A5A0 + i;
   end

   // Latency 0 answers in the strobe cycle itself
   assign ready = strobe ? (lat == 4'h0) : (busy_r && cnt_r == lat);
   // Idle bus shows the inverse of the last word, never a stale copy
   assign rdata = ready ? mem[idx] : ~last_r;

   always @(posedge clk)
   begin
      cnt_r <= strobe ? 4'h1 : cnt_r + 4'h1;
      busy_r <= strobe ? (lat != 4'h0) : (busy_r && !ready);
      if (strobe)
      begin
         idx_r <= addr[26:29];
         lanes_r <= lanes;
         wr_r <= wr;
      end
      if (ready)
      begin
         last_r <= rdata;
         for (int b = 0; b < 4; b++)
            if (wrr && wl[b])
               mem[idx][8*b +: 8] <= wdata[8*b +: 8];
      end
   end
endmodule
`default_nettype wire

/* File: bench/lmbm_master_props.sv */
`timescale 1ns/100ps
`default_nettype none
module lmbm_master_props
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        data_transfer_strobe_r,
   input  wire logic        read_strobe_r,
   input  wire logic        write_strobe_r,
   input  wire logic        data_side_ready,
   input  wire logic [0:3]  lane_sel_r,
   input  wire logic [0:31] data_write_r,
   input  wire logic        drsp_valid_r,
   input  wire logic        fetch_transfer_strobe_r,
   input  wire logic        fetch_in_progress_r,
   input  wire logic        fetch_side_ready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_waiting;
      (read_strobe_r || write_strobe_r) && !data_side_ready;
   endsequence
   sequence s_done;
      (read_strobe_r || write_strobe_r) && data_side_ready;
   endsequence

   a_no_new_take: assert property (s_waiting |=> !data_transfer_strobe_r)
      else $error("new data transfer while one is pending");
   a_read_hold: assert property (read_strobe_r && !data_side_ready |=> read_strobe_r)
      else $error("read in progress dropped before ready");
   a_read_gapless: assert property (read_strobe_r && data_side_ready |=>
      read_strobe_r == (data_transfer_strobe_r && !write_strobe_r))
      else $error("read in progress wrong after ready");
   a_write_gapless: assert property (write_strobe_r && data_side_ready |=>
      write_strobe_r == (data_transfer_strobe_r && !read_strobe_r))
      else $error("write in progress wrong after ready");
   a_lane_legal: assert property (data_transfer_strobe_r |-> lane_sel_r inside
      {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
      else $error("illegal lane select pattern");
   a_wdata_stable: assert property (write_strobe_r && !data_side_ready |=>
      $stable(data_write_r))
      else $error("write data changed before ready");
   a_fetch_hold: assert property (fetch_in_progress_r && !fetch_side_ready |=>
      fetch_in_progress_r && !fetch_transfer_strobe_r)
      else $error("fetch dropped or restarted before ready");
   a_resp_delay: assert property (s_done |-> ##2 drsp_valid_r)
      else $error("data response not two cycles after ready");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |->
      !(data_transfer_strobe_r || read_strobe_r || write_strobe_r || fetch_in_progress_r))
      else $error("bus active during reset");
endmodule
`default_nettype wire

/* File: bench/test_local_memory_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none
module test_local_memory_bus_master;
   import lmbm_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b1;
   logic        dcmd_valid = 1'b0, dcmd_write = 1'b0, fcmd_valid = 1'b0;
   logic [1:0]  dcmd_size = SIZE_WORD;
   logic [0:31] dcmd_addr = WORD_ZERO, dcmd_wdata = WORD_ZERO, fcmd_addr = WORD_ZERO;
   logic [3:0]  dlat = 4'h0, flat = 4'h0;
   logic        dcmd_taken_r, drsp_valid_r, drsp_write_r, fcmd_taken_r, frsp_valid_r;
   logic [0:31] drsp_rdata_r, frsp_instr_r, data_addr_r, data_write_r, data_read;
   logic [0:31] instr_addr_r, instr;
   logic [0:3]  lane_sel_r;
   logic        data_transfer_strobe_r, read_strobe_r, write_strobe_r, data_side_ready;
   logic        fetch_transfer_strobe_r, fetch_in_progress_r, fetch_side_ready;
   int          n_mismatch = 0, tests_run = 0;

   always #50 core_clk = ~core_clk;

   lmbm_master DUT (
      .core_clk                (core_clk),
      .rst_b                   (rst_b),
      .dcmd_valid              (dcmd_valid),
      .dcmd_write              (dcmd_write),
      .dcmd_size               (dcmd_size),
      .dcmd_addr               (dcmd_addr),
      .dcmd_wdata              (dcmd_wdata),
      .dcmd_taken_r            (dcmd_taken_r),
      .drsp_valid_r            (drsp_valid_r),
      .drsp_write_r            (drsp_write_r),
      .drsp_rdata_r            (drsp_rdata_r),
      .fcmd_valid              (fcmd_valid),
      .fcmd_addr               (fcmd_addr),
      .fcmd_taken_r            (fcmd_taken_r),
      .frsp_valid_r            (frsp_valid_r),
      .frsp_instr_r            (frsp_instr_r),
      .data_addr_r             (data_addr_r),
      .lane_sel_r              (lane_sel_r),
      .data_write_r            (data_write_r),
      .data_transfer_strobe_r  (data_transfer_strobe_r),
      .read_strobe_r           (read_strobe_r),
      .write_strobe_r          (write_strobe_r),
      .data_read               (data_read),
      .data_side_ready         (data_side_ready),
      .instr_addr_r            (instr_addr_r),
      .fetch_transfer_strobe_r (fetch_transfer_strobe_r),
      .fetch_in_progress_r     (fetch_in_progress_r),
      .instr                   (instr),
      .fetch_side_ready        (fetch_side_ready)
   );
   lmbm_mem_model dmem (.clk(core_clk), .strobe(data_transfer_strobe_r), .wr(write_strobe_r),
      .addr(data_addr_r), .lanes(lane_sel_r), .wdata(data_write_r), .lat(dlat),
      .ready(data_side_ready), .rdata(data_read));
   lmbm_mem_model imem (.clk(core_clk), .strobe(fetch_transfer_strobe_r), .wr(1'b0),
      .addr(instr_addr_r), .lanes(LANE_NONE), .wdata(WORD_ZERO), .lat(flat),
      .ready(fetch_side_ready), .rdata(instr));

   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask

   task automatic check(input logic [0:31] seen, input logic [0:31] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic await(ref logic s, inout int n);
      while (s !== 1'b1 && n < 20)
      begin
         tick();
         n++;
      end
      if (s !== 1'b1)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic t_reset;
      rst_b = 1'b0;
      repeat (2) tick();
      check({28'h0, data_transfer_strobe_r, read_strobe_r, write_strobe_r,
             fetch_in_progress_r}, WORD_ZERO);
      rst_b = 1'b1;
      repeat (3) tick();
   endtask

   // One data transfer; er is the bus write data or the steered load result
   task automatic dop(input logic w, input logic [1:0] sz, input logic [0:31] a,
                      input logic [0:31] wd, input logic [3:0] l, input logic [0:3] el,
                      input logic [0:31] er);
      int n;
      n = 0;
      dlat = l;
      dcmd_valid = 1'b1;
      dcmd_write = w;
      dcmd_size = sz;
      dcmd_addr = a;
      dcmd_wdata = wd;
      tick();
      await(dcmd_taken_r, n);
      dcmd_valid = 1'b0;
      check(data_addr_r, a);
      check({31'h0, data_transfer_strobe_r}, 32'h0000_0001);
      check({28'h0, lane_sel_r}, {28'h0, el});
      check({30'h0, read_strobe_r, write_strobe_r}, {30'h0, !w, w});
      if (w && el != LANE_NONE)
         check(data_write_r, er);
      await(drsp_valid_r, n);
      check({31'h0, drsp_write_r}, {31'h0, w});
      if (!w)
         check(drsp_rdata_r, er);
   endtask

   task automatic b2b(input logic w);
      int n;
      n = 0;
      dlat = 4'h0;
      dcmd_valid = 1'b1;
      dcmd_write = w;
      dcmd_size = SIZE_WORD;
      dcmd_addr = 32'h0000_0030;
      tick();
      await(dcmd_taken_r, n);
      dcmd_addr = 32'h0000_0034;
      tick();
      check({29'h0, dcmd_taken_r, read_strobe_r, write_strobe_r}, {29'h0, 1'b1, !w, w});
      dcmd_valid = 1'b0;
      repeat (3) tick();
   endtask

   // Valid stays up, so the same fetch is retaken only once ready arrives
   task automatic fop(input logic [0:31] a, input logic [3:0] l, input logic [0:31] ei);
      int n;
      n = 0;
      flat = l;
      fcmd_valid = 1'b1;
      fcmd_addr = a;
      tick();
      await(fcmd_taken_r, n);
      check({30'h0, fetch_transfer_strobe_r, fetch_in_progress_r}, 32'h0000_0003);
      check(instr_addr_r, a);
      n = 0;
      tick();
      await(fcmd_taken_r, n);
      check(32'(n), {28'h0, l});
      fcmd_valid = 1'b0;
      n = 0;
      await(frsp_valid_r, n);
      check(frsp_instr_r, ei);
      repeat (3) tick();
   endtask

   initial
   begin
      // Reset falls off time zero so every flop sees a real falling edge
      #1;
      t_reset();
      dop(1'b1, SIZE_WORD, 32'h0000_0010, 32'hCAFE_F00D, 4'h2, LANE_WORD, 32'hCAFE_F00D);
      dop(1'b0, SIZE_WORD, 32'h0000_0010, WORD_ZERO, 4'h0, LANE_WORD, 32'hCAFE_F00D);
      dop(1'b1, SIZE_HALF, 32'h0000_0024, 32'h0000_BEEF, 4'h1, LANE_HI_HALF, 32'hBEEF_BEEF);
      dop(1'b1, SIZE_HALF, 32'h0000_0016, 32'h0000_1234, 4'h0, LANE_LO_HALF, 32'h1234_1234);
      dop(1'b1, SIZE_BYTE, 32'h0000_0027, 32'h0000_0077, 4'h3, 4'h1, 32'h7777_7777);
      dop(1'b1, 2'h3, 32'h0000_0025, 32'h0000_0011, 4'h0, LANE_NONE, WORD_ZERO);
      dop(1'b0, SIZE_WORD, 32'h0000_0024, WORD_ZERO, 4'h2, LANE_WORD, 32'hBEEF_A577);
      dop(1'b0, SIZE_HALF, 32'h0000_0024, WORD_ZERO, 4'h0, LANE_WORD, 32'h0000_BEEF);
      dop(1'b0, SIZE_BYTE, 32'h0000_0026, WORD_ZERO, 4'h0, LANE_WORD, 32'h0000_00A5);
      for (int k = 0; k < 4; k++)
         dop(1'b1, SIZE_BYTE, 32'h0000_0028 + k, {24'h0, 8'h40 + 8'(k)}, 4'(k),
             LANE_BYTE0 >> k, {4{8'h40 + 8'(k)}});
      dop(1'b0, SIZE_WORD, 32'h0000_0028, WORD_ZERO, 4'h1, LANE_WORD, 32'h4041_4243);
      b2b(1'b1);
      b2b(1'b0);
      fop(32'h0000_0014, 4'h0, 32'hA5A5_A5A5);
      fop(32'h0000_0018, 4'h3, 32'hA5A5_A5A6);
      t_reset();
      dop(1'b0, SIZE_WORD, 32'h0000_0030, WORD_ZERO, 4'h1, LANE_WORD, WORD_ZERO);
      tally_and_finish();
   end
endmodule

bind lmbm_master lmbm_master_props u_props (
   .core_clk                (core_clk),
   .rst_b                   (rst_b),
   .data_transfer_strobe_r  (data_transfer_strobe_r),
   .read_strobe_r           (read_strobe_r),
   .write_strobe_r          (write_strobe_r),
   .data_side_ready         (data_side_ready),
   .lane_sel_r              (lane_sel_r),
   .data_write_r            (data_write_r),
   .drsp_valid_r            (drsp_valid_r),
   .fetch_transfer_strobe_r (fetch_transfer_strobe_r),
   .fetch_in_progress_r     (fetch_in_progress_r),
   .fetch_side_ready        (fetch_side_ready)
);
`default_nettype wire
